// ===== pvft_defines.svh
`ifndef PVFT_DEFINES_SVH
`define PVFT_DEFINES_SVH

// system clock rate
`define PVFT_SYS_CLK_MHZ     250
// pixel clock divider: 2-bit phase counter, clock high in upper half
`define PVFT_DIV_LAST        2'h3
`define PVFT_DIV_HIGH_BIT    1
// horizontal geometry in pixel clocks
`define PVFT_LS_WIDTH        12'h008
`define PVFT_HBP             12'h004
`define PVFT_HFP             12'h008
// vertical geometry in lines
`define PVFT_FS_LINES        12'h001
`define PVFT_VFP_LINES       8'h02
`define PVFT_VBLANK_BASE     8'h06
`define PVFT_VBLANK_STEP     8'h08
// timing figures in their own units
`define PVFT_TDR_SETUP_MS    1.0
`define PVFT_TDR_HOLD_MS     1.0
`define PVFT_RST_LOW_US      1.25
// widths
`define PVFT_PIX_W           24
`define PVFT_FIFO_DEPTH      16

`endif

// ===== pvft_pkg.sv
package pvft_pkg;

    typedef enum logic [1:0] {
        PVFT_ST_RESET,
        PVFT_ST_WAIT,
        PVFT_ST_RUN
    } pvft_state_e;

    typedef struct packed {
        pvft_state_e st;
        logic [1:0]  div;
        logic        pclk;
        logic [11:0] hcnt;
        logic [11:0] vcnt;
        logic        fs;
        logic        ls;
        logic        de;
        logic [23:0] pix;
        logic        tdr;
        logic [19:0] since_flag;
        logic [19:0] since_fs;
        logic [8:0]  rst_cnt;
        logic        dev_rst_n;
        logic        underrun;
        logic        frame_pulse;
    } pvft_state_s;

endpackage

// ===== pvft_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module pvft_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
        logic [WIDTH-1:0]            out_q;
        logic                        out_valid;
        logic                        in_ready;
    } pvft_fifo_s;

    pvft_fifo_s q;
    pvft_fifo_s d;
    logic       push;
    logic       pop;
    logic       mem_pop;

    // storage array plus a registered head word; depth must be 2**n
    always_comb begin
        d       = q;
        push    = in_valid & q.in_ready;
        pop     = out_ready & q.out_valid;
        mem_pop = (q.count != '0) & (~q.out_valid | pop);
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = AW'(q.wr + 1'b1);
        end
        if (mem_pop) begin
            d.out_q     = q.mem[q.rd];
            d.rd        = AW'(q.rd + 1'b1);
            d.out_valid = 1'b1;
        end else if (pop) begin
            d.out_valid = 1'b0;
        end
        d.count    = (AW+1)'(q.count + {{AW{1'b0}}, push}
                     - {{AW{1'b0}}, mem_pop});
        d.in_ready = (d.count < (AW+1)'(DEPTH));
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q          <= '0;
            q.in_ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign in_ready  = q.in_ready;
    assign out_valid = q.out_valid;
    assign out_data  = q.out_q;

endmodule
`default_nettype wire

// ===== pvft_source.sv
`timescale 1ns/10ps
`default_nettype none

`include "pvft_defines.svh"

// Notes on behaviour
// - frame sync is held high for one whole line at the start of a frame.
// - at least two lines pass from the frame sync rise to the first active line.
// - at least one line passes after the last active line before frame sync.
// - total vertical blanking is 6 plus 8 times the larger of 1 and the ratio.
// - line sync stays high between 4 and 128 pixel clocks, here 8.
// - the data strobe rises at least 4 pixel clocks after line sync rises.
// - line sync rises at least 8 pixel clocks after the data strobe falls.
// - sync, strobe and pixel bus change mid-cycle outside a reset, so they are stable at the rise.
// - the 3D-ready flag changes at least 1 ms before any frame sync edge.
// - the 3D-ready flag holds at least 1 ms after any frame sync edge.
// - the device reset output is driven low for at least 1.25 us.
// - the 24 MHz reference clock comes from an outside oscillator, not here.
module pvft_source
    import pvft_pkg::*;
#(
    parameter logic [19:0] TDR_SETUP_CYC =
        20'($rtoi($ceil(`PVFT_TDR_SETUP_MS * 1000.0 * `PVFT_SYS_CLK_MHZ))),
    parameter logic [19:0] TDR_HOLD_CYC  =
        20'($rtoi($ceil(`PVFT_TDR_HOLD_MS * 1000.0 * `PVFT_SYS_CLK_MHZ)))
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        run,
    input  wire logic [11:0] active_width,
    input  wire logic [11:0] active_height,
    input  wire logic [3:0]  line_ratio,
    input  wire logic        three_d_req,
    input  wire logic        dev_reset_req,
    input  wire logic        pix_in_valid,
    output var  logic        pix_in_ready,
    input  wire logic [23:0] pix_in_data,
    output var  logic        pixel_clock,
    output var  logic        frame_sync,
    output var  logic        line_sync,
    output var  logic        data_valid_strobe,
    output var  logic [23:0] pixel_bus,
    output var  logic        three_d_ready_flag,
    output var  logic        device_reset_n,
    output var  logic        frame_start,
    output var  logic        underrun
);
    // reset low time in system clocks, rounded up
    localparam logic [8:0] RST_LOW_CYC =
        9'($rtoi($ceil(`PVFT_RST_LOW_US * `PVFT_SYS_CLK_MHZ)));

    pvft_state_s q;
    pvft_state_s d;

    logic        fifo_valid;
    logic        fifo_ready;
    logic [23:0] fifo_data;
    logic        tick;
    logic        wrap_line;
    logic        wrap_frame;
    logic        start_ok;
    logic [11:0] h_n;
    logic [11:0] v_n;
    logic [11:0] vbp;
    logic [11:0] line_last;
    logic [11:0] frame_last;
    logic [11:0] de_start;
    logic [11:0] de_end;
    logic        de_n;

    // minimum total vertical blanking in lines
    function automatic logic [7:0] vblank_lines(input logic [3:0] ratio);
        logic [3:0] r;
        r = (ratio == 4'h0) ? 4'h1 : ratio;
        return 8'(`PVFT_VBLANK_BASE + `PVFT_VBLANK_STEP * {4'h0, r});
    endfunction

    // frame sync level for a line index
    function automatic logic fs_at(input logic [11:0] v);
        return (v < `PVFT_FS_LINES);
    endfunction

    // line sync level for a pixel index
    function automatic logic ls_at(input logic [11:0] h);
        return (h < `PVFT_LS_WIDTH);
    endfunction

    pvft_fifo #(
        .WIDTH (`PVFT_PIX_W),
        .DEPTH (`PVFT_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (pix_in_valid),
        .in_ready  (pix_in_ready),
        .in_data   (pix_in_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    // geometry derived from the size inputs
    always_comb begin
        vbp        = 12'(vblank_lines(line_ratio) - `PVFT_VFP_LINES);
        de_start   = 12'(`PVFT_LS_WIDTH + `PVFT_HBP);
        de_end     = 12'(de_start + active_width);
        line_last  = 12'(de_end + `PVFT_HFP - 12'h001);
        frame_last = 12'(vbp + active_height
                     + {4'h0, `PVFT_VFP_LINES} - 12'h001);
    end

    // next raster position and strobe for the coming pixel clock
    always_comb begin
        tick       = (q.div == `PVFT_DIV_LAST);
        wrap_line  = (q.hcnt == line_last);
        wrap_frame = wrap_line & (q.vcnt == frame_last);
        start_ok   = run & (q.since_flag >= TDR_SETUP_CYC);
        h_n        = wrap_line ? 12'h000 : 12'(q.hcnt + 12'h001);
        v_n        = wrap_frame ? 12'h000
                   : (wrap_line ? 12'(q.vcnt + 12'h001) : q.vcnt);
        if (q.st == PVFT_ST_WAIT) begin
            h_n = 12'h000;
            v_n = 12'h000;
        end
        de_n = (v_n >= vbp) & (v_n < 12'(vbp + active_height))
             & (h_n >= de_start) & (h_n < de_end);
    end

    // pop one fifo word for each launched active pixel
    assign fifo_ready = tick & de_n & (q.st != PVFT_ST_RESET)
                      & ((q.st == PVFT_ST_RUN & ~wrap_frame) | start_ok);

    // whole block state update
    always_comb begin
        d             = q;
        d.frame_pulse = 1'b0;

        // pixel clock by division; outputs launch on its falling edge
        d.div  = 2'(q.div + 2'h1);
        d.pclk = d.div[`PVFT_DIV_HIGH_BIT];

        // device reset pulse held low for the full count
        if (dev_reset_req) begin
            d.dev_rst_n = 1'b0;
            d.rst_cnt   = 9'h000;
        end else if (!q.dev_rst_n) begin
            if (q.rst_cnt >= RST_LOW_CYC - 9'h001) begin
                d.dev_rst_n = 1'b1;
            end else begin
                d.rst_cnt = 9'(q.rst_cnt + 9'h001);
            end
        end

        // raster sequencer
        case (q.st)
            PVFT_ST_RESET: begin
                d.fs = 1'b0;
                d.ls = 1'b0;
                d.de = 1'b0;
                if (q.dev_rst_n && tick) begin
                    d.st = PVFT_ST_WAIT;
                end
            end
            PVFT_ST_WAIT: begin
                if (tick && start_ok) begin
                    d.st          = PVFT_ST_RUN;
                    d.hcnt        = h_n;
                    d.vcnt        = v_n;
                    d.fs          = fs_at(v_n);
                    d.ls          = ls_at(h_n);
                    d.de          = de_n;
                    d.frame_pulse = 1'b1;
                end
            end
            PVFT_ST_RUN: begin
                if (tick) begin
                    if (wrap_frame && !start_ok) begin
                        // hold idle until run is set and the 3D-ready setup has passed
                        d.st   = PVFT_ST_WAIT;
                        d.hcnt = 12'h000;
                        d.vcnt = 12'h000;
                        d.fs   = 1'b0;
                        d.ls   = 1'b0;
                        d.de   = 1'b0;
                    end else begin
                        d.hcnt        = h_n;
                        d.vcnt        = v_n;
                        d.fs          = fs_at(v_n);
                        d.ls          = ls_at(h_n);
                        d.de          = de_n;
                        d.frame_pulse = wrap_frame;
                    end
                end
            end
            default: begin
                d.st = PVFT_ST_RESET;
            end
        endcase

        // pixel word for the launched pixel, zero when starved
        if (fifo_ready) begin
            d.pix = fifo_valid ? fifo_data : '0;
            if (!fifo_valid) begin
                d.underrun = 1'b1;
            end
        end else if (tick) begin
            d.pix = '0;
        end

        // any reset request stops the raster at once
        if (dev_reset_req || !q.dev_rst_n) begin
            d.st   = PVFT_ST_RESET;
            d.hcnt = 12'h000;
            d.vcnt = 12'h000;
            d.fs   = 1'b0;
            d.ls   = 1'b0;
            d.de   = 1'b0;
        end

        // time since the last frame sync edge
        if (d.fs != q.fs) begin
            d.since_fs = 20'h00000;
        end else if (q.since_fs < TDR_HOLD_CYC) begin
            d.since_fs = 20'(q.since_fs + 20'h00001);
        end

        // 3D-ready flag follows the request only outside the hold window
        if ((three_d_req != q.tdr) && (q.since_fs >= TDR_HOLD_CYC)
            && (d.fs == q.fs)) begin
            d.tdr        = three_d_req;
            d.since_flag = 20'h00000;
        end else if (q.since_flag < TDR_SETUP_CYC) begin
            d.since_flag = 20'(q.since_flag + 20'h00001);
        end
    end

    // single state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            q            <= '0;
            q.st         <= PVFT_ST_RESET;
            q.since_flag <= TDR_SETUP_CYC;
            q.since_fs   <= TDR_HOLD_CYC;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign pixel_clock        = q.pclk;
    assign frame_sync         = q.fs;
    assign line_sync          = q.ls;
    assign data_valid_strobe  = q.de;
    assign pixel_bus          = q.pix;
    assign three_d_ready_flag = q.tdr;
    assign device_reset_n     = q.dev_rst_n;
    assign frame_start        = q.frame_pulse;
    assign underrun           = q.underrun;

endmodule
`default_nettype wire

// ===== pvft_source_props.sv
`timescale 1ns/10ps
`default_nettype none
module pvft_source_props
    import pvft_pkg::*;
#(
    parameter logic [19:0] TDR_SETUP_CYC = 20'h000C8,
    parameter logic [19:0] TDR_HOLD_CYC  = 20'h000C8
) (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [11:0] active_height,
    input wire logic [3:0]  line_ratio,
    input wire logic        pixel_clock,
    input wire logic        frame_sync,
    input wire logic        line_sync,
    input wire logic        data_valid_strobe,
    input wire logic        three_d_ready_flag,
    input wire logic        device_reset_n
);
    logic [11:0] ln_q;
    logic [3:0]  rq_q;
    logic [19:0] sf_q;
    logic [19:0] sv_q;
    logic [8:0]  lo_q;
    logic        ls_q;
    logic        fl_q;
    logic        fs_q;
    // line index in frame, gaps since flag and sync edges, reset low time
    always_ff @(posedge sys_clk) begin
        ls_q <= line_sync;
        fl_q <= three_d_ready_flag;
        fs_q <= frame_sync;
        if (!rstn) begin
            ln_q <= 12'hFFF;
            rq_q <= 4'h1;
            sf_q <= 20'hFFFFF;
            sv_q <= 20'hFFFFF;
            lo_q <= 9'h000;
        end else begin
            if (line_sync && !ls_q && frame_sync) begin
                ln_q <= 12'h000;
                rq_q <= line_ratio;
            end else if (line_sync && !ls_q) begin
                ln_q <= ln_q + 12'h001;
            end
            sf_q <= (three_d_ready_flag != fl_q) ? 20'h00000 :
                sf_q + 20'(~&sf_q);
            sv_q <= (frame_sync != fs_q) ? 20'h00000 : sv_q + 20'(~&sv_q);
            lo_q <= device_reset_n ? 9'h000 : lo_q + 9'(~&lo_q);
        end
    end
    // two clock domains here, so every property names its own clock
    sequence s_ls_hi;
        line_sync[*8] ##1 !line_sync;
    endsequence
    sequence s_hbp;
        !data_valid_strobe[*8] ##1 !data_valid_strobe[*4];
    endsequence
    property p_ls_width;
        @(posedge pixel_clock) disable iff (!rstn)
            $rose(line_sync) |-> s_ls_hi;
    endproperty
    a_ls_width: assert property (p_ls_width) else $error("sync width");
    property p_hbp;
        @(posedge pixel_clock) disable iff (!rstn)
            $rose(line_sync) |-> s_hbp;
    endproperty
    a_hbp: assert property (p_hbp) else $error("back porch");
    property p_hfp;
        @(posedge pixel_clock) disable iff (!rstn)
            $fell(data_valid_strobe) |-> !line_sync[*8];
    endproperty
    a_hfp: assert property (p_hfp) else $error("front porch");
    property p_vsw;
        @(posedge pixel_clock) disable iff (!rstn)
            $fell(frame_sync) |-> $rose(line_sync);
    endproperty
    a_vsw: assert property (p_vsw) else $error("frame sync width");
    property p_vblank;
        @(posedge sys_clk) disable iff (!rstn)
            $rose(frame_sync) && ln_q != 12'hFFF |->
            ln_q + 12'h001 - active_height >=
            12'h006 + (rq_q > 4'h1 ? {5'h00, rq_q, 3'h0} : 12'h008);
    endproperty
    a_vblank: assert property (p_vblank) else $error("blanking");
    property p_setup;
        @(posedge sys_clk) disable iff (!rstn)
            $changed(frame_sync) |-> sf_q >= TDR_SETUP_CYC;
    endproperty
    a_setup: assert property (p_setup) else $error("flag setup");
    property p_hold;
        @(posedge sys_clk) disable iff (!rstn)
            $changed(three_d_ready_flag) |-> sv_q >= TDR_HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("flag hold");
    property p_rst;
        @(posedge sys_clk) disable iff (!rstn)
            $rose(device_reset_n) |-> lo_q >= 9'h139;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pulse");
    property p_stable;
        @(posedge sys_clk) disable iff (!rstn)
            $changed(line_sync) || $changed(data_valid_strobe) |->
            $fell(pixel_clock);
    endproperty
    a_stable: assert property (p_stable) else $error("mid edge");
endmodule
bind pvft_source pvft_source_props #(
    .TDR_SETUP_CYC (TDR_SETUP_CYC),
    .TDR_HOLD_CYC  (TDR_HOLD_CYC)
) pvft_source_props_inst (
    .sys_clk, .rstn, .active_height, .line_ratio, .pixel_clock,
    .frame_sync, .line_sync, .data_valid_strobe, .three_d_ready_flag,
    .device_reset_n
);
`default_nettype wire

// ===== pvft_device_model.sv
`timescale 1ns/10ps
`default_nettype none
module pvft_device_model
    import pvft_pkg::*;
(
    input  wire logic        pixel_clock,
    input  wire logic        frame_sync,
    input  wire logic        line_sync,
    input  wire logic        data_valid_strobe,
    input  wire logic [23:0] pixel_bus,
    input  wire logic        device_reset_n,
    output var  logic [11:0] frame_lines,
    output var  logic [11:0] line_pixels
);
    logic [11:0] ln_q = 12'h000;
    logic [11:0] px_q = 12'h000;
    logic        ls_q = 1'b0;
    logic [23:0] pix_q [$];
    // sample the link on the rising pixel clock edge
    always @(posedge pixel_clock) begin
        ls_q <= line_sync;
        if (!device_reset_n) begin
            ln_q <= 12'h000;
        end else if (line_sync && !ls_q) begin
            frame_lines <= frame_sync ? ln_q : frame_lines;
            ln_q <= frame_sync ? 12'h001 : ln_q + 12'h001;
            line_pixels <= (px_q != 12'h000) ? px_q : line_pixels;
            px_q <= 12'h000;
        end
        if (data_valid_strobe) begin
            pix_q.push_back(pixel_bus);
            px_q <= px_q + 12'h001;
        end
    end
endmodule
`default_nettype wire

// ===== pvft_source_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pvft_source_tb_top
    import pvft_pkg::*;
;
    localparam logic [19:0] TDR_CYC = 20'h000C8;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        run = 1'b0;
    logic [11:0] active_width = 12'h004;
    logic [11:0] active_height = 12'h008;
    logic [3:0]  line_ratio = 4'h1;
    logic        three_d_req = 1'b0;
    logic        dev_reset_req = 1'b0;
    logic        pix_in_valid = 1'b0;
    logic [23:0] pix_in_data = 24'h000000;
    logic        pix_in_ready, pixel_clock, frame_sync, line_sync;
    logic        data_valid_strobe, three_d_ready_flag, device_reset_n;
    logic        frame_start, underrun;
    logic [23:0] pixel_bus;
    logic [11:0] frame_lines, line_pixels;
    int          n_errors = 0;
    int          checks_done = 0;
    int          acc;
    pvft_source #(.TDR_SETUP_CYC(TDR_CYC), .TDR_HOLD_CYC(TDR_CYC))
    pvft_source_inst (.sys_clk, .rstn, .run, .active_width, .active_height,
        .line_ratio, .three_d_req, .dev_reset_req, .pix_in_valid,
        .pix_in_ready, .pix_in_data, .pixel_clock, .frame_sync, .line_sync,
        .data_valid_strobe, .pixel_bus, .three_d_ready_flag,
        .device_reset_n, .frame_start, .underrun);
    pvft_device_model pvft_device_model_inst (.pixel_clock, .frame_sync,
        .line_sync, .data_valid_strobe, .pixel_bus, .device_reset_n,
        .frame_lines, .line_pixels);
    // system clock
    always #2 sys_clk = ~sys_clk;
    function automatic logic [23:0] pat(input int i);
        return 24'hA50000 + 24'(i);
    endfunction
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp({23'h000000, got}, {23'h000000, exp});
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // offer one word and hold it until taken or the limit runs out
    task automatic push(input logic [23:0] w, input int lim, output bit ok);
        @(negedge sys_clk);
        pix_in_valid = 1'b1;
        pix_in_data = w;
        ok = 1'b0;
        // ready is read while settled; the word goes at the next rise
        repeat (lim) begin
            ok = (pix_in_ready === 1'b1);
            @(posedge sys_clk);
            if (ok) begin
                break;
            end
            @(negedge sys_clk);
        end
    endtask
    task automatic wait_frame;
        int n;
        n = 0;
        while (frame_start !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_bit(frame_start, 1'b1);
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic t_dev_reset;
        repeat (300) @(negedge sys_clk);
        cmp_bit(device_reset_n, 1'b0);
        repeat (20) @(negedge sys_clk);
        cmp_bit(device_reset_n, 1'b1);
    endtask
    // fill the fifo until refused, then drain it through one frame
    task automatic t_stream;
        bit ok;
        int i;
        acc = 0;
        ok = 1'b1;
        while (ok) begin
            push(pat(acc), 2, ok);
            acc += ok;
        end
        cmp_bit(acc >= 16, 1'b1);
        @(negedge sys_clk);
        run = 1'b1;
        fork
            begin
                for (i = acc; i < 32; i++) push(pat(i), 5000, ok);
                @(negedge sys_clk);
                pix_in_valid = 1'b0;
            end
            wait_frame();
        join
        wait_frame();
        run = 1'b0;
        cmp(24'(frame_lines), 24'h000016);
        cmp(24'(line_pixels), 24'h000004);
        cmp_bit(underrun, 1'b0);
        for (i = 0; i < 32; i++) begin
            cmp(pvft_device_model_inst.pix_q[i], pat(i));
        end
    endtask
    // ratio codes 0 to 3, with the ready flag toggled between runs
    task automatic t_ratio;
        int r;
        for (r = 0; r < 4; r++) begin
            repeat (5000) @(negedge sys_clk);
            line_ratio = 4'(r);
            three_d_req = r[0];
            run = 1'b1;
            wait_frame();
            wait_frame();
            run = 1'b0;
            cmp(24'(frame_lines), 24'(14 + 8 * (r > 1 ? r : 1)));
            cmp_bit(three_d_ready_flag, r[0]);
        end
        cmp_bit(underrun, 1'b1);
    endtask
    task automatic t_dev_pulse;
        repeat (5000) @(negedge sys_clk);
        dev_reset_req = 1'b1;
        @(negedge sys_clk);
        dev_reset_req = 1'b0;
        t_dev_reset();
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        t_dev_reset();
        t_stream();
        t_ratio();
        t_dev_pulse();
        tally_and_finish();
    end
    // watchdog
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
